/* File: src/bsr_regs.sv */
// Debug status/control and breakpoint match registers behind serial commands
`timescale 1ns/1ps
`default_nettype none
module bsr_regs #(
   parameter int ADDR_W = 16
) (
   clk,
   rst,
   cmd_valid,
   cmd_code,
   cmd_wdata,
   rsp_valid,
   rsp_data,
   cpu_addr,
   cpu_addr_valid,
   cpu_in_wait_stop,
   cpu_background,
   bgnd_cmd,
   mem_cmd_done,
   mem_cmd_ws_conflict,
   background_permit,
   breakpoint_enable,
   force_tag_select,
   comm_clock_select,
   bkpt_force_req,
   bkpt_tag_req,
   bgnd_entry_req,
   wait_stop_wake_req
);
   input wire logic clk; // Selected debug clock
   input wire logic rst; // Normal reset, synchronous, active high
   input wire logic cmd_valid; // One-cycle pulse: decoded serial command
   input wire logic [7:0] cmd_code; // Command code byte
   input wire logic [15:0] cmd_wdata; // Write payload: control byte in low bits, match word in all 16 bits
   output logic rsp_valid; // One-cycle pulse: read answer ready
   output logic [15:0] rsp_data; // Read answer: status byte in low bits, match word in all 16 bits
   input wire logic [ADDR_W-1:0] cpu_addr; // CPU address bus
   input wire logic cpu_addr_valid; // Address bus carries an access
   input wire logic cpu_in_wait_stop; // CPU sits in wait or stop
   input wire logic cpu_background; // CPU halted in background mode
   input wire logic bgnd_cmd; // Pulse: background command decoded
   input wire logic mem_cmd_done; // Pulse: memory access command ended
   input wire logic mem_cmd_ws_conflict; // With done: hit wait/stop
   output logic background_permit; // Background entry allowed
   output logic breakpoint_enable; // Breakpoint logic enabled
   output logic force_tag_select; // 1 force, 0 tag
   output logic comm_clock_select; // 1 bus clock, 0 alternate source
   output logic bkpt_force_req; // Pulse: force halt at next boundary
   output logic bkpt_tag_req; // Pulse: tag the opcode being fetched
   output logic bgnd_entry_req; // Pulse: enter background mode
   output logic wait_stop_wake_req; // Pulse: leave wait/stop for halt

   // All state of the block except the comparator's request pair in one record
   typedef struct packed {
      logic permit;
      logic bkpt_en;
      logic force_tag;
      logic clk_sel;
      logic ws_sticky;
      logic ws_fail;
      logic active;
      logic [15:0] match;
      logic rsp_v;
      logic [15:0] rsp;
      logic bgnd_req;
      logic wake_req;
   } bsr_regs_st_t;

   bsr_regs_st_t st_q;
   bsr_regs_st_t st_d;
   logic [7:0] status_byte; // Assembled status/control view
   logic ws_status; // Live wait/stop status bit
   logic match_force; // Force request from comparator
   logic match_tag; // Tag request from comparator

   // Comparator against the CPU address bus
   bsr_match #(
      .ADDR_W(ADDR_W)
   ) u_match (
      .clk(clk),
      .rst(rst),
      .bkpt_enable(st_q.bkpt_en),
      .force_select(st_q.force_tag),
      .match_addr(st_q.match[ADDR_W-1:0]),
      .cpu_addr(cpu_addr),
      .cpu_addr_valid(cpu_addr_valid),
      .force_req(match_force),
      .tag_req(match_tag)
   );

   // Status byte seen by the read command
   always_comb begin
      ws_status = cpu_in_wait_stop || (st_q.ws_sticky && cpu_background);
      status_byte = 8'h00;
      status_byte[bsr_pkg::BIT_PERMIT] = st_q.permit;
      status_byte[bsr_pkg::BIT_ACTIVE] = st_q.active;
      status_byte[bsr_pkg::BIT_BKPT_EN] = st_q.bkpt_en;
      status_byte[bsr_pkg::BIT_FORCE_TAG] = st_q.force_tag;
      status_byte[bsr_pkg::BIT_CLK_SEL] = st_q.clk_sel;
      status_byte[bsr_pkg::BIT_WS_STATUS] = ws_status;
      status_byte[bsr_pkg::BIT_WS_FAIL] = st_q.ws_fail;
      status_byte[bsr_pkg::BIT_DV_FAIL] = bsr_pkg::DV_FAIL_VALUE;
   end

   // Next-state logic: command decode, status tracking, wake requests
   always_comb begin
      st_d = st_q;
      st_d.rsp_v = 1'b0;
      st_d.bgnd_req = 1'b0;
      st_d.wake_req = 1'b0;
      st_d.active = cpu_background;
      // Remember a wake from wait/stop until the CPU resumes the user code
      if (bgnd_cmd && cpu_in_wait_stop) begin
         st_d.ws_sticky = 1'b1;
      end else if (!cpu_background && !cpu_in_wait_stop) begin
         st_d.ws_sticky = 1'b0;
      end
      if (cmd_valid) begin
         if (cmd_code == bsr_pkg::CMD_READ_STATUS) begin
            st_d.rsp_v = 1'b1;
            st_d.rsp = {8'h00, status_byte};
         end else if (cmd_code == bsr_pkg::CMD_WRITE_CONTROL) begin
            // permit locked while halted; sticky once set
            if (!st_q.active && cmd_wdata[bsr_pkg::BIT_PERMIT]) begin
               st_d.permit = 1'b1;
            end
            st_d.bkpt_en = cmd_wdata[bsr_pkg::BIT_BKPT_EN];
            st_d.force_tag = cmd_wdata[bsr_pkg::BIT_FORCE_TAG];
            st_d.clk_sel = cmd_wdata[bsr_pkg::BIT_CLK_SEL];
            // status bits untouched by the write
         end else if (cmd_code == bsr_pkg::CMD_MATCH_READ) begin
            st_d.rsp_v = 1'b1;
            st_d.rsp = st_q.match;
         end else if (cmd_code == bsr_pkg::CMD_MATCH_WRITE) begin
            st_d.match = cmd_wdata;
         end else begin
            // Other commands belong to other logic
            st_d.rsp_v = 1'b0;
         end
      end
      // failure flag; set by a conflicted access, cleared by a clean access
      if (mem_cmd_done) begin
         st_d.ws_fail = mem_cmd_ws_conflict;
      end
      if (st_q.permit && bgnd_cmd && !cpu_background) begin
         st_d.bgnd_req = 1'b1;
         st_d.wake_req = cpu_in_wait_stop;
      end
   end

   // State register; cleared by normal reset
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.permit <= bsr_pkg::RST_PERMIT;
         st_q.bkpt_en <= bsr_pkg::RST_BKPT_EN;
         st_q.force_tag <= bsr_pkg::RST_FORCE_TAG;
         st_q.clk_sel <= bsr_pkg::RST_CLK_SEL;
         st_q.match <= bsr_pkg::RST_MATCH;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs; breakpoint requests also need permit to halt the core
   assign background_permit = st_q.permit;
   assign breakpoint_enable = st_q.bkpt_en;
   assign force_tag_select = st_q.force_tag;
   assign comm_clock_select = st_q.clk_sel;
   assign bkpt_force_req = match_force && st_q.permit;
   assign bkpt_tag_req = match_tag && st_q.permit;
   assign bgnd_entry_req = st_q.bgnd_req;
   assign wait_stop_wake_req = st_q.wake_req;
   assign rsp_valid = st_q.rsp_v;
   assign rsp_data = st_q.rsp;

   // Assertions
   // Checks watch registered state and outputs, not the host's own drive
   // All assertions but chk_bkpt_reset are muted while the synchronous reset is held; the cover statements are not
   // permit locked
   chk_permit_locked: assert property (
      @(posedge clk) disable iff (rst)
      (st_q.active && !st_q.permit) |=> !st_q.permit)
      else $error("Permit changed while halted");
   chk_permit_sticky: assert property (
      @(posedge clk) disable iff (rst)
      st_q.permit |=> st_q.permit)
      else $error("Permit dropped without reset");
   chk_permit_gate: assert property (
      @(posedge clk) disable iff (rst)
      !st_q.permit |=> !bgnd_entry_req)
      else $error("Background entry without permit");
   chk_status_read: assert property (
      @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_code == bsr_pkg::CMD_READ_STATUS)
      |=> rsp_valid && rsp_data[15:8] == 8'h00)
      else $error("Status read not answered");
   chk_match_write: assert property (
      @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_code == bsr_pkg::CMD_MATCH_WRITE)
      |=> st_q.match == $past(cmd_wdata))
      else $error("Match write lost");
   chk_match_read: assert property (
      @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_code == bsr_pkg::CMD_MATCH_READ)
      |=> rsp_valid && rsp_data == $past(st_q.match))
      else $error("Match read answer wrong");
   chk_bkpt_disabled: assert property (
      @(posedge clk) disable iff (rst)
      (!breakpoint_enable ##1 !breakpoint_enable)
      |-> !bkpt_force_req && !bkpt_tag_req)
      else $error("Breakpoint while disabled");
   chk_force_hit: assert property (
      @(posedge clk) disable iff (rst)
      (st_q.permit && st_q.bkpt_en && st_q.force_tag && cpu_addr_valid
      && cpu_addr == st_q.match[ADDR_W-1:0]) |=> bkpt_force_req)
      else $error("Force request missing");
   chk_tag_hit: assert property (
      @(posedge clk) disable iff (rst)
      bkpt_tag_req |-> !$past(st_q.force_tag) && !bkpt_force_req)
      else $error("Tag request in force mode");
   chk_dv_zero: assert property (
      @(posedge clk) disable iff (rst)
      rsp_valid && $past(cmd_code) == bsr_pkg::CMD_READ_STATUS
      |-> !rsp_data[bsr_pkg::BIT_DV_FAIL])
      else $error("Data-valid failure reported");
   chk_ws_fail: assert property (
      @(posedge clk) disable iff (rst)
      (mem_cmd_done && mem_cmd_ws_conflict) |=> st_q.ws_fail)
      else $error("Wait/stop failure not flagged");
   chk_ro_fail: assert property (
      @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_code == bsr_pkg::CMD_WRITE_CONTROL && !mem_cmd_done)
      |=> $stable(st_q.ws_fail))
      else $error("Control write altered a status bit");
   chk_active_track: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> st_q.active == $past(cpu_background))
      else $error("Active bit does not follow halt");
   chk_ws_status: assert property (
      @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_code == bsr_pkg::CMD_READ_STATUS && cpu_in_wait_stop)
      |=> rsp_data[bsr_pkg::BIT_WS_STATUS])
      else $error("Wait/stop status not reported");
   chk_clk_sel: assert property (
      @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_code == bsr_pkg::CMD_WRITE_CONTROL
      && cmd_wdata[bsr_pkg::BIT_CLK_SEL]) |=> comm_clock_select)
      else $error("Clock select write lost");
   chk_bkpt_reset: assert property (
      @(posedge clk)
      $fell(rst) |-> !breakpoint_enable && !background_permit
      && !comm_clock_select)
      else $error("Control bits not cleared by reset");
   chk_wake: assert property (
      @(posedge clk) disable iff (rst)
      (st_q.permit && bgnd_cmd && cpu_in_wait_stop && !cpu_background)
      |=> wait_stop_wake_req && bgnd_entry_req)
      else $error("Wake from wait/stop missing");
   cov_force: cover property (@(posedge clk) bkpt_force_req);
   cov_tag: cover property (@(posedge clk) bkpt_tag_req);
   cov_wake: cover property (@(posedge clk) wait_stop_wake_req);
   cov_fail: cover property (@(posedge clk) st_q.ws_fail);
   cov_halt: cover property (@(posedge clk) bgnd_entry_req);
endmodule // bsr_regs
`default_nettype wire

/* File: src/bsr_pkg.sv */
// Package with constants for the background debug status and match registers
package bsr_pkg;
   // Serial command codes that reach the two debug registers
   localparam logic [7:0] CMD_READ_STATUS = 8'hE4;
   localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
   localparam logic [7:0] CMD_MATCH_READ = 8'hE2;
   localparam logic [7:0] CMD_MATCH_WRITE = 8'hC2;
   // Bit positions inside debug_status_control
   localparam int BIT_PERMIT = 7;
   localparam int BIT_ACTIVE = 6;
   localparam int BIT_BKPT_EN = 5;
   localparam int BIT_FORCE_TAG = 4;
   localparam int BIT_CLK_SEL = 3;
   localparam int BIT_WS_STATUS = 2;
   localparam int BIT_WS_FAIL = 1;
   localparam int BIT_DV_FAIL = 0;
   // Values after reset
   localparam logic RST_PERMIT = 1'b0;
   localparam logic RST_BKPT_EN = 1'b0;
   localparam logic RST_FORCE_TAG = 1'b0;
   localparam logic RST_CLK_SEL = 1'b0;
   localparam logic [15:0] RST_MATCH = 16'h0000;
   // Data-valid failure never raised: no slow memory behind the core
   localparam logic DV_FAIL_VALUE = 1'b0;
endpackage

/* File: src/bsr_match.sv */
// Address comparator that turns a bus match into force or tag requests
`timescale 1ns/1ps
`default_nettype none
module bsr_match #(
   parameter int ADDR_W = 16
) (
   clk,
   rst,
   bkpt_enable,
   force_select,
   match_addr,
   cpu_addr,
   cpu_addr_valid,
   force_req,
   tag_req
);
   input wire logic clk;
   input wire logic rst;
   input wire logic bkpt_enable;
   input wire logic force_select;
   input wire logic [ADDR_W-1:0] match_addr;
   input wire logic [ADDR_W-1:0] cpu_addr;
   input wire logic cpu_addr_valid;
   output logic force_req;
   output logic tag_req;

   // Registered request pair
   typedef struct packed {
      logic force_r;
      logic tag_r;
   } bsr_match_st_t;

   bsr_match_st_t st_q;
   bsr_match_st_t st_d;
   logic hit; // Raw comparison, gated by enable

   // Compare the address bus; disabled breakpoint yields no request
   always_comb begin
      hit = bkpt_enable && cpu_addr_valid && (cpu_addr == match_addr);
      st_d = '0;
      st_d.force_r = hit && force_select;
      st_d.tag_r = hit && !force_select;
   end

   // One register stage keeps the compare off the CPU timing path
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign force_req = st_q.force_r;
   assign tag_req = st_q.tag_r;
endmodule // bsr_match
`default_nettype wire

/* File: tb/bsr_host_model.sv */
// Debug host model that issues serial register commands
`timescale 1ns/1ps
`default_nettype none
module bsr_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_data
);
   // Idle bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // one-cycle command
   // Idle payload is inverted so stale data never looks valid
   task automatic send(input logic [7:0] c, input logic [15:0] w);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_wdata <= w;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_wdata <= ~w;
   endtask
   // Read: answer taken at the edge that shows it, bounded wait
   task automatic read(input logic [7:0] c, output logic [15:0] d,
                       output logic ok);
      send(c, 16'h0000);
      ok = 1'b0;
      d = 16'hFFFF;
      for (int i = 0; i < 3 && !ok; i++) begin
         @(posedge clk);
         if (rsp_valid === 1'b1) begin
            ok = 1'b1;
            d = rsp_data;
         end
      end
   endtask
endmodule // bsr_host_model
`default_nettype wire

/* File: tb/bsr_regs_tb.sv */
// Self-checking bench for the debug status and match registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
 $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module bsr_regs_tb;
   logic clk = 1'b0, rst = 1'b1, cmd_valid, rsp_valid;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rsp_data, cpu_addr = 16'h0000, m, rd;
   logic cpu_addr_valid = 1'b0, cpu_in_wait_stop = 1'b0, ok;
   logic cpu_background = 1'b0, bgnd_cmd = 1'b0, mem_cmd_done = 1'b0;
   logic mem_cmd_ws_conflict = 1'b0, background_permit, breakpoint_enable;
   logic force_tag_select, comm_clock_select, bkpt_force_req, bkpt_tag_req;
   logic bgnd_entry_req, wait_stop_wake_req;
   int bad_count = 0, n_checks = 0, cyc = 0, nf = 0, nt = 0, ne = 0, nw = 0;
   int f0, t0, e0;
   // Clock at 100 MHz
   always #5 clk = ~clk;
   bsr_regs #(.ADDR_W(16)) u_bsr_regs (.clk(clk), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cpu_addr(cpu_addr),
      .cpu_addr_valid(cpu_addr_valid), .cpu_in_wait_stop(cpu_in_wait_stop),
      .cpu_background(cpu_background), .bgnd_cmd(bgnd_cmd),
      .mem_cmd_done(mem_cmd_done), .mem_cmd_ws_conflict(mem_cmd_ws_conflict),
      .background_permit(background_permit),
      .breakpoint_enable(breakpoint_enable),
      .force_tag_select(force_tag_select),
      .comm_clock_select(comm_clock_select),
      .bkpt_force_req(bkpt_force_req), .bkpt_tag_req(bkpt_tag_req),
      .bgnd_entry_req(bgnd_entry_req),
      .wait_stop_wake_req(wait_stop_wake_req));
   bsr_host_model u_bsr_host_model (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data));
   // Count request pulses; the run is cut short if it hangs
   always @(posedge clk) begin
      cyc++;
      nf += (bkpt_force_req === 1'b1);
      nt += (bkpt_tag_req === 1'b1);
      ne += (bgnd_entry_req === 1'b1);
      nw += (wait_stop_wake_req === 1'b1);
      if (cyc > 3000) begin
         bad_count++;
         test_done();
      end
   end
   // Expected status byte; the data-valid flag is always clear
   function automatic logic [15:0] st(input logic [6:0] b);
      return {8'h00, b, bsr_pkg::DV_FAIL_VALUE};
   endfunction
   // Read one register through the host and compare
   task automatic chk_rd(input logic [7:0] c, input logic [15:0] e);
      u_bsr_host_model.read(c, rd, ok);
      `CHK(ok, 1'b1)
      `CHK(rd, e)
   endtask
   task automatic tick(input logic pulse_bg);
      @(posedge clk);
      bgnd_cmd <= pulse_bg;
      @(posedge clk);
      bgnd_cmd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(56645));
      do_reset();
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h00));
      chk_rd(bsr_pkg::CMD_MATCH_READ, 16'h0000);
      // Permit write while halted must be dropped
      cpu_background <= 1'b1;
      u_bsr_host_model.send(bsr_pkg::CMD_WRITE_CONTROL, 16'h0080);
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h20));
      cpu_background <= 1'b0;
      e0 = ne;
      tick(1'b1);
      `CHK(ne, e0)
      // Read-only bits ignore a write of all ones
      u_bsr_host_model.send(bsr_pkg::CMD_WRITE_CONTROL, 16'h00FF);
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h5C));
      e0 = ne;
      tick(1'b1);
      `CHK(ne, e0 + 1)
      // Permit cannot be cleared by a write; unknown code is ignored
      u_bsr_host_model.send(bsr_pkg::CMD_WRITE_CONTROL, 16'h0028);
      u_bsr_host_model.send(8'h90, 16'h0000);
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h54));
      @(negedge clk);
      `CHK({background_permit, breakpoint_enable}, 2'h3)
      `CHK({force_tag_select, comm_clock_select}, 2'h1)
      // Disabled, force and tag modes against random addresses
      for (int k = 0; k < 3; k++) begin
         m = 16'($urandom);
         u_bsr_host_model.send(bsr_pkg::CMD_MATCH_WRITE, m);
         u_bsr_host_model.send(bsr_pkg::CMD_WRITE_CONTROL, k == 0 ? 16'h0098
                               : k == 1 ? 16'h0038 : 16'h0028);
         chk_rd(bsr_pkg::CMD_MATCH_READ, m);
         f0 = nf;
         t0 = nt;
         for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            cpu_addr_valid <= 1'b1;
            cpu_addr <= (i == 4) ? m
                        : m ^ (16'h0001 + 16'($urandom % 16'hFFFF));
         end
         @(posedge clk);
         cpu_addr_valid <= 1'b0;
         cpu_addr <= ~m;
         repeat (3) @(posedge clk);
         `CHK(nf, f0 + (k == 1))
         `CHK(nt, t0 + (k == 2))
      end
      // Wait/stop, wake by background command, then halted
      cpu_in_wait_stop <= 1'b1;
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h56));
      e0 = nw;
      tick(1'b1);
      `CHK(nw, e0 + 1)
      cpu_in_wait_stop <= 1'b0;
      cpu_background <= 1'b1;
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h76));
      // Conflicted memory command, then a clean retry
      mem_cmd_ws_conflict <= 1'b1;
      mem_cmd_done <= 1'b1;
      @(posedge clk);
      mem_cmd_done <= 1'b0;
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h77));
      mem_cmd_ws_conflict <= 1'b0;
      mem_cmd_done <= 1'b1;
      @(posedge clk);
      mem_cmd_done <= 1'b0;
      chk_rd(bsr_pkg::CMD_READ_STATUS, st(7'h76));
      cpu_background <= 1'b0;
      do_reset();
      @(negedge clk);
      `CHK(background_permit, bsr_pkg::RST_PERMIT)
      test_done();
   end
endmodule // bsr_regs_tb
`default_nettype wire
